// ### tc1_pkg.sv
package tc1_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] RELOAD_OFS  = 8'h04;
  localparam logic [7:0] COUNT_OFS   = 8'h08;
  localparam logic [7:0] COMPARE_OFS = 8'h0C;
  localparam logic [7:0] CAPTURE_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS  = 8'h14;
  localparam logic [7:0] MASK_OFS    = 8'h18;
  localparam logic [7:0] COMMAND_OFS = 8'h1C;

  // Field positions of counter_control_one.
  localparam int unsigned CTL_LVL_BIT  = 15;
  localparam int unsigned CTL_SAT_BIT  = 14;
  localparam int unsigned CTL_CKD_LSB  = 8;
  localparam int unsigned CTL_PRE_BIT  = 7;
  localparam int unsigned CTL_CMS_LSB  = 5;
  localparam int unsigned CTL_DIR_BIT  = 4;
  localparam int unsigned CTL_OPM_BIT  = 3;
  localparam int unsigned CTL_URS_BIT  = 2;
  localparam int unsigned CTL_UPDATE_DISABLE_BIT = 1;
  localparam int unsigned CTL_RUN_BIT  = 0;
  localparam logic [15:0] CTRL_WMASK   = 16'hC3FF;
  localparam logic [15:0] CTRL_RST     = 16'h0000;

  // Other fields.
  localparam int unsigned CMD_UG_BIT  = 0;
  localparam int unsigned CMP_OUT_BIT = 16;
  localparam int unsigned CAP_LVL_BIT = 16;
  localparam int unsigned ST_UPD_BIT  = 0;
  localparam int unsigned ST_CMP_BIT  = 1;
  localparam int unsigned ST_CAP_BIT  = 2;
  localparam int unsigned ST_W        = 3;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] CAP_SAT     = 16'hFFFF;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CMS_EDGE = 2'h0,
    CMS_C1   = 2'h1,
    CMS_C2   = 2'h2,
    CMS_C3   = 2'h3
  } tc1_cms_e;

  typedef enum logic [1:0] {
    CKD_DIV1 = 2'h0,
    CKD_DIV2 = 2'h1,
    CKD_DIV4 = 2'h2,
    CKD_RSVD = 2'h3
  } tc1_ckd_e;

  // Byte-lane merge of a bus write into an old register word.
  function automatic logic [31:0] tc1_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : tc1_merge

endpackage : tc1_pkg

// ### tc1_reg_if.sv
`timescale 1ns/100ps
// Register access path between the bus slave and the timer core.
interface tc1_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface : tc1_reg_if

// ### tc1_dts_div.sv
`timescale 1ns/100ps
// Sampling tick for the dead-time generator and the input filters.
module tc1_dts_div
  import tc1_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [1:0] ckd_i,
  output logic            tick_o
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] last;
  logic       tick_d;

  // The reserved code falls back to the undivided clock so it never stalls.
  always_comb begin
    case (tc1_ckd_e'(ckd_i))
      CKD_DIV2: last = 2'h1;
      CKD_DIV4: last = 2'h3;
      default:  last = 2'h0;
    endcase
    tick_d = (cnt_q >= last);
    cnt_d  = tick_d ? 2'h0 : 2'(cnt_q + 2'h1);
  end

  // Counter and tick register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // The code is watched in every cycle that decides a tick, so a code change is never flagged.
  div_four_gap_a: assert property (
    (ckd_i == CKD_DIV4) && tick_o ##1 (ckd_i == CKD_DIV4)[*2]
    |=> !tick_o && !$past(tick_o) && !$past(tick_o, 2))
    else $error("Divide-by-four tick came too early.");
  div_two_gap_a: assert property (
    (ckd_i == CKD_DIV2) && $stable(ckd_i) && tick_o
    |=> !tick_o ##1 (tick_o || ($past(ckd_i) != CKD_DIV2)))
    else $error("Divide-by-two tick is not every second cycle.");

endmodule : tc1_dts_div

// ### tc1_axil.sv
`timescale 1ns/100ps
// AXI4-Lite slave that turns bus transfers into register strobes.
module tc1_axil
  import tc1_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  tc1_reg_if.bus           rif
);

  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_d, rvalid_d, aw_take, w_take, ar_take;
  logic [1:0]  bresp_d, rresp_d;

  // Address and data are held separately, so they may arrive in either order.
  always_comb begin
    awready_o   = !aw_have_q && !bvalid_o;
    wready_o    = !w_have_q && !bvalid_o;
    arready_o   = !rvalid_o;
    aw_take     = awvalid_i && awready_o;
    w_take      = wvalid_i && wready_o;
    ar_take     = arvalid_i && arready_o;
    awaddr_d    = aw_take ? awaddr_i : awaddr_q;
    wdata_d     = w_take ? wdata_i : wdata_q;
    wstrb_d     = w_take ? wstrb_i : wstrb_q;
    aw_have_d   = aw_have_q || aw_take;
    w_have_d    = w_have_q || w_take;
    rif.wr_en   = aw_have_d && w_have_d && !bvalid_o;
    rif.wr_addr = awaddr_d;
    rif.wr_data = wdata_d;
    rif.wr_strb = wstrb_d;
    rif.rd_addr = araddr_i;
    bvalid_d    = bvalid_o && !bready_i;
    bresp_d     = bresp_o;
    if (rif.wr_en) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    rvalid_d = rvalid_o && !rready_i;
    rdata_d  = rdata_o;
    rresp_d  = rresp_o;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = rif.rd_hit ? rif.rd_data : WORD_ZERO;
      rresp_d  = rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Channel state registers.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= WORD_ZERO;
      wstrb_q   <= 4'h0;
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OKAY;
      rvalid_o  <= 1'b0;
      rdata_o   <= WORD_ZERO;
      rresp_o   <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_o  <= bvalid_d;
      bresp_o   <= bresp_d;
      rvalid_o  <= rvalid_d;
      rdata_o   <= rdata_d;
      rresp_o   <= rresp_d;
    end
  end

endmodule : tc1_axil

// ### tc1_core.sv
`timescale 1ns/100ps
// Behaviour
// - Bit 15 adds input level at capture bit 16.
// - Bit 14 saturates capture to FFFF after a wrap.
// - Field 9:8 divides sampling tick by 1,2,4.
// - Bit 7 buffers reload value until update.
// - Mode 00 counts edge-aligned by direction bit.
// - Mode 01 alternates; compare flag only counting down.
// - Mode 10 alternates; compare flag only counting up.
// - Mode 11 alternates; compare flag both directions.
// - Bit 4: zero counts up, one counts down.
// - Center or encoder mode: hardware sets direction.
// - Bit 3 clears run at next update event.
// - Bit 2: only wrap raises update request.
// - Bit 2 clear: wrap, command or slave request.
// - Bit 1 blocks updates; reinit still happens.
// - Bit 0 runs counter; trigger may set it.
module tc1_core
  import tc1_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic [7:0]  AXI_AWADDR_I,
  input  wire logic        AXI_AWVALID_I,
  output logic             AXI_AWREADY_O,
  input  wire logic [31:0] AXI_WDATA_I,
  input  wire logic [3:0]  AXI_WSTRB_I,
  input  wire logic        AXI_WVALID_I,
  output logic             AXI_WREADY_O,
  output logic [1:0]       AXI_BRESP_O,
  output logic             AXI_BVALID_O,
  input  wire logic        AXI_BREADY_I,
  input  wire logic [7:0]  AXI_ARADDR_I,
  input  wire logic        AXI_ARVALID_I,
  output logic             AXI_ARREADY_O,
  output logic [31:0]      AXI_RDATA_O,
  output logic [1:0]       AXI_RRESP_O,
  output logic             AXI_RVALID_O,
  input  wire logic        AXI_RREADY_I,
  input  wire logic        CAPTURE_PIN_I,
  input  wire logic        ENCODER_MODE_I,
  input  wire logic        ENCODER_DOWN_I,
  input  wire logic        SLAVE_UPDATE_I,
  input  wire logic        SLAVE_RESET_I,
  input  wire logic        TRIGGER_START_I,
  output logic             UPDATE_EVENT_O,
  output logic             UPDATE_REQUEST_O,
  output logic             COMPARE_FLAG_O,
  output logic             DTS_TICK_O,
  output logic             IRQ_O
);

  typedef enum logic {CNT_UP, CNT_DOWN} tc1_dir_e;

  tc1_reg_if rif ();

  logic [15:0]   ctrl_q, ctrl_d, reload_pre_q, reload_pre_d, reload_act_q, reload_act_d;
  logic [15:0]   count_q, count_d;
  logic [16:0]   cmp_q, cmp_d, cap_q, cap_d;
  logic [ST_W-1:0] status_q, status_d, mask_q, mask_d, st_set;
  tc1_dir_e      dir_q, dir_d;
  logic          ovf_seen_q, ovf_seen_d, uev_d, ureq_d, cmp_flag_d;
  logic          cap_s1_q, cap_s2_q, cap_s3_q;
  logic [31:0]   m_ctrl, m_rel, m_cnt, m_cmp, m_mask, m_clr;
  logic          wr_ctrl, wr_rel, wr_cnt, wr_cmp, wr_st, wr_mask, wr_cmd;
  logic          run, center, eff_down, ovf, unf, ug, reinit, uev_src, match, cap_evt;
  tc1_cms_e      center_align_select;

  // Bus slave feeding the register strobes.
  tc1_axil u_axil (
    .clk_i     (SYS_CLK_I),
    .arst_n_i  (ARST_N_I),
    .awaddr_i  (AXI_AWADDR_I),
    .awvalid_i (AXI_AWVALID_I),
    .awready_o (AXI_AWREADY_O),
    .wdata_i   (AXI_WDATA_I),
    .wstrb_i   (AXI_WSTRB_I),
    .wvalid_i  (AXI_WVALID_I),
    .wready_o  (AXI_WREADY_O),
    .bresp_o   (AXI_BRESP_O),
    .bvalid_o  (AXI_BVALID_O),
    .bready_i  (AXI_BREADY_I),
    .araddr_i  (AXI_ARADDR_I),
    .arvalid_i (AXI_ARVALID_I),
    .arready_o (AXI_ARREADY_O),
    .rdata_o   (AXI_RDATA_O),
    .rresp_o   (AXI_RRESP_O),
    .rvalid_o  (AXI_RVALID_O),
    .rready_i  (AXI_RREADY_I),
    .rif       (rif.bus)
  );

  // Sampling tick for dead time and filters.
  tc1_dts_div u_div (
    .clk_i    (SYS_CLK_I),
    .arst_n_i (ARST_N_I),
    .ckd_i    (ctrl_q[CTL_CKD_LSB +: 2]),
    .tick_o   (DTS_TICK_O)
  );

  // Write decode and byte-lane merges against each register's old value; status and command writes merge against zero.
  assign wr_ctrl = rif.wr_en && (rif.wr_addr == CTRL_OFS);
  assign wr_rel  = rif.wr_en && (rif.wr_addr == RELOAD_OFS);
  assign wr_cnt  = rif.wr_en && (rif.wr_addr == COUNT_OFS);
  assign wr_cmp  = rif.wr_en && (rif.wr_addr == COMPARE_OFS);
  assign wr_st   = rif.wr_en && (rif.wr_addr == STATUS_OFS);
  assign wr_mask = rif.wr_en && (rif.wr_addr == MASK_OFS);
  assign wr_cmd  = rif.wr_en && (rif.wr_addr == COMMAND_OFS);
  assign m_ctrl  = tc1_merge({16'h0000, ctrl_q}, rif.wr_data, rif.wr_strb);
  assign m_rel   = tc1_merge({16'h0000, reload_pre_q}, rif.wr_data, rif.wr_strb);
  assign m_cnt   = tc1_merge({16'h0000, count_q}, rif.wr_data, rif.wr_strb);
  assign m_cmp   = tc1_merge({15'h0000, cmp_q}, rif.wr_data, rif.wr_strb);
  assign m_mask  = tc1_merge({29'h0000_0000, mask_q}, rif.wr_data, rif.wr_strb);
  assign m_clr   = tc1_merge(WORD_ZERO, rif.wr_data, rif.wr_strb);
  assign rif.wr_hit = wr_ctrl || wr_rel || wr_cnt || wr_cmp || wr_st || wr_mask || wr_cmd
                      || (rif.wr_addr == CAPTURE_OFS);

  // Counting direction and wrap detection; center and encoder modes own the direction.
  always_comb begin
    center_align_select      = tc1_cms_e'(ctrl_q[CTL_CMS_LSB +: 2]);
    run      = ctrl_q[CTL_RUN_BIT];
    center   = (center_align_select != CMS_EDGE);
    if (center) begin
      eff_down = (dir_q == CNT_DOWN);
    end else if (ENCODER_MODE_I) begin
      eff_down = ENCODER_DOWN_I;
    end else begin
      eff_down = ctrl_q[CTL_DIR_BIT];
    end
    ovf      = run && !eff_down && (count_q == reload_act_q);
    unf      = run && eff_down && (count_q == CNT_ZERO);
    ug       = wr_cmd && m_clr[CMD_UG_BIT];
    reinit   = ug || SLAVE_RESET_I;
    uev_src  = ovf || unf || ug || SLAVE_UPDATE_I;
    uev_d    = uev_src && !ctrl_q[CTL_UPDATE_DISABLE_BIT];
    ureq_d   = uev_d && (ctrl_q[CTL_URS_BIT] ? (ovf || unf) : 1'b1);
  end

  // Control, reload and counter next values.
  always_comb begin
    ctrl_d       = ctrl_q;
    reload_pre_d = reload_pre_q;
    reload_act_d = reload_act_q;
    count_d      = count_q;
    dir_d        = dir_q;
    if (wr_ctrl) begin
      ctrl_d = m_ctrl[15:0] & CTRL_WMASK;
    end
    if (uev_d && ctrl_q[CTL_OPM_BIT]) begin
      ctrl_d[CTL_RUN_BIT] = 1'b0;
    end
    if (TRIGGER_START_I) begin
      ctrl_d[CTL_RUN_BIT] = 1'b1;
    end
    if (wr_rel) begin
      reload_pre_d = m_rel[15:0];
      if (!ctrl_q[CTL_PRE_BIT]) begin
        reload_act_d = m_rel[15:0];
      end
    end
    if (uev_d && ctrl_q[CTL_PRE_BIT]) begin
      reload_act_d = reload_pre_q;
    end
    // Center modes assume the counter starts from the bottom going up.
    if (run && !center) begin
      if (eff_down) begin
        count_d = unf ? reload_act_q : 16'(count_q - CNT_ONE);
      end else begin
        count_d = ovf ? CNT_ZERO : 16'(count_q + CNT_ONE);
      end
    end else if (run) begin
      if (ovf) begin
        count_d = 16'(count_q - CNT_ONE);
        dir_d   = CNT_DOWN;
      end else if (unf) begin
        count_d = 16'(count_q + CNT_ONE);
        dir_d   = CNT_UP;
      end else begin
        count_d = eff_down ? 16'(count_q - CNT_ONE) : 16'(count_q + CNT_ONE);
      end
    end
    // Reinitialisation works even while updates are disabled.
    if (reinit) begin
      count_d = (eff_down && !center) ? reload_act_q : CNT_ZERO;
      dir_d   = CNT_UP;
    end
    if (wr_cnt) begin
      count_d = m_cnt[15:0];
    end
  end

  // Compare and capture next values.
  always_comb begin
    cmp_d      = wr_cmp ? m_cmp[16:0] : cmp_q;
    match      = cmp_q[CMP_OUT_BIT] && run && (count_q == cmp_q[15:0]);
    case (center_align_select)
      CMS_EDGE: cmp_flag_d = match;
      CMS_C1:   cmp_flag_d = match && eff_down;
      CMS_C2:   cmp_flag_d = match && !eff_down;
      CMS_C3:   cmp_flag_d = match;
      default:  cmp_flag_d = 1'b0;
    endcase
    // Both pin edges capture, so the level bit tells rising from falling.
    cap_evt    = !cmp_q[CMP_OUT_BIT] && (cap_s2_q != cap_s3_q);
    cap_d      = cap_q;
    if (cap_evt) begin
      cap_d[CAP_LVL_BIT] = ctrl_q[CTL_LVL_BIT] && cap_s2_q;
      cap_d[15:0] = (ctrl_q[CTL_SAT_BIT] && ovf_seen_q) ? CAP_SAT : count_q;
    end
    // A wrap in the capture cycle is kept for the next capture.
    ovf_seen_d = (ovf || unf) ? 1'b1 : (cap_evt ? 1'b0 : ovf_seen_q);
    mask_d     = wr_mask ? m_mask[ST_W-1:0] : mask_q;
    st_set     = '0;
    st_set[ST_UPD_BIT] = ureq_d;
    st_set[ST_CMP_BIT] = cmp_flag_d;
    st_set[ST_CAP_BIT] = cap_evt;
  end

  // Sticky status bits: a new event wins over a write-one-to-clear.
  for (genvar i = 0; i < ST_W; i++) begin : g_status
    assign status_d[i] = st_set[i] || (status_q[i] && !(wr_st && m_clr[i]));
  end

  // Read multiplexer; the direction bit shows the hardware direction.
  always_comb begin
    rif.rd_hit  = 1'b1;
    rif.rd_data = WORD_ZERO;
    case (rif.rd_addr)
      CTRL_OFS:    rif.rd_data = {16'h0000, ctrl_q[15:5], eff_down, ctrl_q[3:0]};
      RELOAD_OFS:  rif.rd_data = {16'h0000, reload_pre_q};
      COUNT_OFS:   rif.rd_data = {16'h0000, count_q};
      COMPARE_OFS: rif.rd_data = {15'h0000, cmp_q};
      CAPTURE_OFS: rif.rd_data = {15'h0000, cap_q};
      STATUS_OFS:  rif.rd_data = {29'h0000_0000, status_q};
      MASK_OFS:    rif.rd_data = {29'h0000_0000, mask_q};
      COMMAND_OFS: rif.rd_data = WORD_ZERO;
      default:     rif.rd_hit  = 1'b0;
    endcase
  end

  assign IRQ_O = |(status_q & mask_q);

  // All state registers; the capture pin passes two flops before use.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_q           <= CTRL_RST;
      reload_pre_q     <= CNT_ZERO;
      reload_act_q     <= CNT_ZERO;
      count_q          <= CNT_ZERO;
      dir_q            <= CNT_UP;
      cmp_q            <= '0;
      cap_q            <= '0;
      ovf_seen_q       <= 1'b0;
      status_q         <= '0;
      mask_q           <= '0;
      cap_s1_q         <= 1'b0;
      cap_s2_q         <= 1'b0;
      cap_s3_q         <= 1'b0;
      UPDATE_EVENT_O   <= 1'b0;
      UPDATE_REQUEST_O <= 1'b0;
      COMPARE_FLAG_O   <= 1'b0;
    end else begin
      ctrl_q           <= ctrl_d;
      reload_pre_q     <= reload_pre_d;
      reload_act_q     <= reload_act_d;
      count_q          <= count_d;
      dir_q            <= dir_d;
      cmp_q            <= cmp_d;
      cap_q            <= cap_d;
      ovf_seen_q       <= ovf_seen_d;
      status_q         <= status_d;
      mask_q           <= mask_d;
      cap_s1_q         <= CAPTURE_PIN_I;
      cap_s2_q         <= cap_s1_q;
      cap_s3_q         <= cap_s2_q;
      UPDATE_EVENT_O   <= uev_d;
      UPDATE_REQUEST_O <= ureq_d;
      COMPARE_FLAG_O   <= cmp_flag_d;
    end
  end

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  one_pulse_stop_a: assert property (
    uev_d && ctrl_q[CTL_OPM_BIT] && !TRIGGER_START_I && !wr_ctrl
    |=> !ctrl_q[CTL_RUN_BIT] && UPDATE_EVENT_O)
    else $error("One-pulse mode did not stop the counter.");
  update_block_a: assert property (
    ctrl_q[CTL_UPDATE_DISABLE_BIT] && !wr_ctrl |=> !UPDATE_EVENT_O)
    else $error("Update event seen while updates are disabled.");
  reinit_update_disable_a: assert property (
    ctrl_q[CTL_UPDATE_DISABLE_BIT] && ug && !center && !eff_down && !wr_cnt |=> count_q == CNT_ZERO)
    else $error("Update command failed to reinitialise the counter.");
  source_only_a: assert property (
    ctrl_q[CTL_URS_BIT] && !ovf && !unf |=> !UPDATE_REQUEST_O)
    else $error("Update request raised without a wrap.");
  source_any_a: assert property (
    !ctrl_q[CTL_URS_BIT] && !ctrl_q[CTL_UPDATE_DISABLE_BIT] && (ug || SLAVE_UPDATE_I)
    |=> UPDATE_REQUEST_O ##1 status_q[ST_UPD_BIT])
    else $error("Command or slave update gave no request.");
  edge_wrap_a: assert property (
    !center && !eff_down && run && count_q == reload_act_q && !reinit && !wr_cnt
    |=> count_q == CNT_ZERO)
    else $error("Up counter did not wrap to zero.");
  down_step_a: assert property (
    !center && ctrl_q[CTL_DIR_BIT] && !ENCODER_MODE_I && run && count_q != CNT_ZERO
    && !reinit && !wr_cnt |=> count_q == 16'($past(count_q) - CNT_ONE))
    else $error("Down counter did not decrement.");
  halt_hold_a: assert property (
    !run && !reinit && !wr_cnt |=> $stable(count_q))
    else $error("Counter moved while stopped.");
  center_turn_a: assert property (
    center && run && ovf && !reinit && !wr_cnt && !wr_ctrl |=> dir_q == CNT_DOWN && eff_down)
    else $error("Center mode did not turn down at the top.");
  saturate_a: assert property (
    cap_evt && ctrl_q[CTL_SAT_BIT] && ovf_seen_q |=> cap_q[15:0] == CAP_SAT)
    else $error("Capture did not saturate after a wrap.");
  level_off_a: assert property (
    cap_evt && !ctrl_q[CTL_LVL_BIT] |=> !cap_q[CAP_LVL_BIT])
    else $error("Level bit set while indication is off.");
  mode_one_a: assert property (
    center_align_select == CMS_C1 && !eff_down |=> !COMPARE_FLAG_O)
    else $error("Mode one flagged while counting up.");
  mode_two_a: assert property (
    center_align_select == CMS_C2 && eff_down |=> !COMPARE_FLAG_O)
    else $error("Mode two flagged while counting down.");
  mode_three_a: assert property (
    center_align_select == CMS_C3 && match |=> COMPARE_FLAG_O)
    else $error("Mode three missed a compare match.");
  preload_off_a: assert property (
    wr_rel && !ctrl_q[CTL_PRE_BIT] && !uev_d |=> reload_act_q == reload_pre_q)
    else $error("Unbuffered reload did not take effect at once.");

  center_run_c: cover property (center && run && ovf ##[1:200] unf);
  one_pulse_c:  cover property (ctrl_q[CTL_OPM_BIT] && run ##[1:300] !run);
  capture_c:    cover property (cap_evt && ctrl_q[CTL_SAT_BIT] && ovf_seen_q);
  irq_c:        cover property (!IRQ_O ##1 IRQ_O);

endmodule : tc1_core

// ### tb_timer_counter_control_one.sv
`timescale 1ns/100ps
module tb_timer_counter_control_one
  import tc1_pkg::*;
;
  logic        clk, rst_n, awv, wv, bre, arv, rre, trg, pin;
  logic        awr, wr_o, bv, arr, rv, ev, rq, cf, tk, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, q;
  logic [1:0]  br, rr, rsp;
  int          num_errors, samples_checked, n_ev, n_rq, n_cf, n_tk, c0, c1;

  tc1_core tc1_core_i (.SYS_CLK_I(clk), .ARST_N_I(rst_n),
    .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
    .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_o),
    .AXI_BRESP_O(br), .AXI_BVALID_O(bv), .AXI_BREADY_I(bre),
    .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
    .AXI_RDATA_O(rd), .AXI_RRESP_O(rr), .AXI_RVALID_O(rv), .AXI_RREADY_I(rre),
    .CAPTURE_PIN_I(pin), .ENCODER_MODE_I(1'b0), .ENCODER_DOWN_I(1'b0),
    .SLAVE_UPDATE_I(1'b0), .SLAVE_RESET_I(1'b0), .TRIGGER_START_I(trg),
    .UPDATE_EVENT_O(ev), .UPDATE_REQUEST_O(rq), .COMPARE_FLAG_O(cf),
    .DTS_TICK_O(tk), .IRQ_O(irq));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulses are counted on the falling edge so the count never races the launching edge.
  always @(negedge clk) begin
    n_ev += ev;
    n_rq += rq;
    n_cf += cf;
    n_tk += tk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One bus transfer; ready and valid are read before the edge's own updates land.
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    if (w) begin
      {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
    end else begin
      {ara, arv, rre} <= {a, 2'b11};
    end
    // Only the watchdog ends a wait that never gets its answer.
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_o) wv <= 1'b0;
      if (arv && arr) arv <= 1'b0;
      if (bre && bv) begin
        rsp = br;
        bre <= 1'b0;
        break;
      end
      if (rre && rv) begin
        {rsp, q} = {rr, rd};
        rre <= 1'b0;
        break;
      end
    end
  endtask : axi

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi(1'b0, a, WORD_ZERO);
    chk(nm, q, e);
  endtask : rdc

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // A hung handshake must still end the run with a verdict.
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  // Main sequence.
  initial begin
    {rst_n, awv, wv, bre, arv, rre, trg, pin, awa, ara, wd} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl_rst", CTRL_OFS, WORD_ZERO);
    axi(1'b1, CTRL_OFS, 32'h0000_FE9E);
    chk("wr_rsp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    rdc("ctrl_rw", CTRL_OFS, 32'h0000_C29E);
    axi(1'b0, 8'h40, WORD_ZERO);
    chk("bad_rsp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Software update with each request source setting.
    for (int u = 0; u < 2; u++) begin
      axi(1'b1, CTRL_OFS, u << 2);
      {c0, c1} = {n_ev, n_rq};
      axi(1'b1, COMMAND_OFS, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk("ug_event", n_ev - c0, 1);
      chk("ug_request", n_rq - c1, 1 - u);
    end
    axi(1'b1, MASK_OFS, 32'h0000_0001);
    chk("irq_set", {31'h0, irq}, 1);
    axi(1'b1, STATUS_OFS, 32'h0000_0001);
    chk("irq_clr", {31'h0, irq}, 0);
    axi(1'b1, CTRL_OFS, 32'h0000_0002);
    axi(1'b1, COUNT_OFS, 32'h0000_0007);
    c0 = n_ev;
    axi(1'b1, COMMAND_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("update_disable_event", n_ev - c0, 0);
    rdc("update_disable_reinit", COUNT_OFS, WORD_ZERO);
    // One-pulse runs, started by the trigger counting up and by software counting down.
    axi(1'b1, RELOAD_OFS, 32'h0000_0003);
    axi(1'b1, COUNT_OFS, WORD_ZERO);
    axi(1'b1, CTRL_OFS, 32'h0000_0008);
    @(posedge clk) trg <= 1'b1;
    @(posedge clk) trg <= 1'b0;
    repeat (20) @(posedge clk);
    rdc("opm_up_ctrl", CTRL_OFS, 32'h0000_0008);
    rdc("opm_up_cnt", COUNT_OFS, WORD_ZERO);
    axi(1'b1, COUNT_OFS, 32'h0000_0002);
    axi(1'b1, CTRL_OFS, 32'h0000_0019);
    repeat (20) @(posedge clk);
    rdc("opm_dn_ctrl", CTRL_OFS, 32'h0000_0018);
    rdc("opm_dn_cnt", COUNT_OFS, 32'h0000_0003);
    // Sampling tick rate for each legal divider code.
    for (int k = 0; k < 3; k++) begin
      axi(1'b1, CTRL_OFS, k << CTL_CKD_LSB);
      repeat (4) @(posedge clk);
      c0 = n_tk;
      repeat (16) @(posedge clk);
      chk("dts_ticks", n_tk - c0, 16 >> k);
    end
    // Compare flags per center mode; mode is changed only while stopped.
    axi(1'b1, COMPARE_OFS, 32'h0001_0002);
    axi(1'b1, RELOAD_OFS, 32'h0000_0004);
    for (int m = 1; m < 4; m++) begin
      axi(1'b1, CTRL_OFS, WORD_ZERO);
      axi(1'b1, COUNT_OFS, WORD_ZERO);
      axi(1'b1, CTRL_OFS, (m << CTL_CMS_LSB) | 1);
      repeat (4) @(posedge clk);
      c0 = n_cf;
      repeat (16) @(posedge clk);
      chk("cmp_flags", n_cf - c0, (m == 3) ? 4 : 2);
    end
    // Capture on both pin edges: the level bit first, then saturation after a wrap.
    axi(1'b1, CTRL_OFS, WORD_ZERO);
    axi(1'b1, COMPARE_OFS, WORD_ZERO);
    axi(1'b1, COUNT_OFS, 32'h0000_0003);
    axi(1'b1, CTRL_OFS, 32'h0000_8000);
    @(posedge clk) pin <= 1'b1;
    repeat (4) @(posedge clk);
    rdc("cap_level", CAPTURE_OFS, 32'h0001_0003);
    axi(1'b1, CTRL_OFS, 32'h0000_C001);
    @(posedge clk) pin <= 1'b0;
    repeat (4) @(posedge clk);
    rdc("cap_saturate", CAPTURE_OFS, 32'h0000_FFFF);
    complete_run();
  end
endmodule : tb_timer_counter_control_one
